/* File: bench/remote_serializer_model.sv */
/* far-end serializer model on the link clock
   assumes back-channel fields straight from the block under test */
`timescale 1ns/1ps
`default_nettype none
module remote_serializer_model
    import selftest_pkg::*;
(
    input wire logic link_clk,
    input wire logic reset_n,
    input wire back_chan_t bc_in,
    input wire logic [PAYLOAD_W-1:0] err_bits,
    input wire logic [3:0] strap_gp,
    output logic remote_selftest_ack,
    output logic remote_awake,
    output logic link_lock,
    output link_frame_t frame
);
    // wake, test entry, lock and frame stream
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            remote_awake <= 1'b0;
            remote_selftest_ack <= 1'b0;
            link_lock <= 1'b0;
            frame <= '0;
        end else begin
            if (bc_in.wake_req)
                remote_awake <= 1'b1;
            // test flag checked on every link clock, once the remote is awake; straps must be set
            remote_selftest_ack <= bc_in.selftest_flag && remote_awake
                && (strap_gp == 4'b0001);
            link_lock <= remote_awake;
            frame.valid <= remote_selftest_ack;
            // zeros in test, flipping junk when not valid
            frame.payload <= remote_selftest_ack ? err_bits : ~frame.payload;
        end
    end
endmodule
`default_nettype wire

/* File: bench/serial_link_bist_checker_properties.sv */
/* checker for the self-test controller ports
   assumes a bind from the bench top; everything sampled on mclk */
`timescale 1ns/1ps
`default_nettype none
module serial_link_bist_checker_properties
    import selftest_pkg::*;
#(
    parameter int ERR_W = ERR_CNT_W
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cfg_selftest_en,
    input wire logic cfg_osc_sel,
    input wire logic power_down,
    input wire logic remote_awake,
    input wire logic bc_frame_strobe,
    input wire logic link_lock,
    input wire back_chan_t bc_out,
    input wire logic test_clk_sel_osc,
    input wire logic pass_out,
    input wire logic lock_out,
    input wire logic test_active,
    input wire logic link_normal,
    input wire logic [ERR_W-1:0] fwd_err_count
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // a test that reached the checking phase and then stopped
    sequence ran_s;
        test_active && pass_out ##1 !test_active;
    endsequence

    link_norm_a: assert property (link_normal == !test_active)
        else $error("link normal flag wrong");
    cfg_start_a: assert property ($rose(cfg_selftest_en) && !power_down |-> ##[1:16] test_active)
        else $error("config enable did not start test");
    osc_sel_a: assert property (cfg_osc_sel |=> test_clk_sel_osc)
        else $error("oscillator select not taken");
    bc_flag_a: assert property (bc_frame_strobe && cfg_selftest_en && test_active |=> bc_out.selftest_flag)
        else $error("back channel flag missing");
    wake_req_a: assert property ($rose(test_active) && !remote_awake |-> ##[0:1] bc_out.wake_req)
        else $error("remote not woken");
    hold_fail_a: assert property ($fell(test_active) && fwd_err_count != 0 |-> ##12 !pass_out [*8])
        else $error("failed result not held low");
    hold_pass_a: assert property (ran_s ##0 fwd_err_count == 0 && !power_down |-> ##12 pass_out [*8])
        else $error("clean result not held high");
    pwr_clear_a: assert property (power_down [*3] |=> !pass_out)
        else $error("power down did not clear result");
    lock_valid_a: assert property (link_lock [*5] |-> lock_out)
        else $error("lock indication lost");
endmodule
`default_nettype wire

/* File: bench/test_serial_link_bist_checker.sv */
/* self-checking bench for the self-test controller
   assumes the remote model and the property checker beside it */
`timescale 1ns/1ps
`default_nettype none
module test_serial_link_bist_checker;
    import selftest_pkg::*;
    logic mclk, link_clk, reset_n, en_pin, sel_pin, power_down, cfg_en, cfg_osc, bc_strobe;
    logic ack, awake, lock, sel_osc, pass_out, lock_out, test_active, link_normal, mon_en;
    logic [PAYLOAD_W-1:0] err_bits;
    logic [3:0] strap_gp;
    logic [ERR_CNT_W-1:0] err_count;
    link_frame_t frame;
    back_chan_t bc_out;
    int fail_count, num_checks, falls, width_ps;
    realtime t_fall;

    serial_link_bist_checker #(.DRAIN_CYCLES(10)) u_dut (.mclk(mclk), .reset_n(reset_n),
        .link_clk(link_clk), .selftest_enable_pin(en_pin), .selftest_clock_select_pin(sel_pin),
        .power_down(power_down), .remote_selftest_ack(ack), .remote_awake(awake),
        .cfg_selftest_en(cfg_en), .cfg_osc_sel(cfg_osc), .bc_frame_strobe(bc_strobe),
        .link_lock(lock), .frame(frame), .bc_out(bc_out), .test_clk_sel_osc(sel_osc),
        .pass_out(pass_out), .lock_out(lock_out), .test_active(test_active),
        .link_normal(link_normal), .fwd_err_count(err_count));
    remote_serializer_model u_remote (.link_clk(link_clk), .reset_n(reset_n), .bc_in(bc_out),
        .err_bits(err_bits), .strap_gp(strap_gp), .remote_selftest_ack(ack), .remote_awake(awake),
        .link_lock(lock), .frame(frame));

    // ****************
    // clocks, strobe, pulse monitor
    // ****************
    initial begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        link_clk = 0;
        #7;
        forever #24 link_clk = ~link_clk;
    end
    initial begin
        bc_strobe = 0;
        forever begin
            repeat (15) @(posedge mclk);
            #2 bc_strobe = 1;
            @(posedge mclk);
            #2 bc_strobe = 0;
        end
    end
    always @(negedge pass_out) if (mon_en) begin
        falls++;
        t_fall = $realtime;
    end
    always @(posedge pass_out) if (mon_en) width_ps = int'(($realtime - t_fall) * 1000);

    // ****************
    // helpers
    // ****************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic wait_pass();
        for (int i = 0; i < 300 && pass_out !== 1'b1; i++) cyc(1);
        check("pass_up", pass_out, 1);
    endtask
    task automatic inject(input logic [PAYLOAD_W-1:0] bits);
        @(posedge link_clk);
        #2 err_bits = bits;
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic s_clk_sel();
        for (int i = 0; i < 4; i++) begin
            sel_pin = i[0];
            cfg_osc = i[1];
            cyc(5);
            check("osc_sel", sel_osc, i[0] | i[1]);
        end
        cfg_osc = 0;
        sel_pin = 0;
    endtask
    task automatic s_errors();
        check("idle_pass", pass_out, 0);
        cfg_en = 1;
        wait_pass();
        check("active", test_active, 1);
        check("normal", link_normal, 0);
        check("lock", lock_out, 1);
        mon_en = 1;
        inject(35'h0_0000_0001);
        inject(35'h4_0000_0000);
        inject(35'h0_0000_0000);
        cyc(5);
        inject(35'h0_0001_0000);
        inject(35'h0_0000_0000);
        cyc(10);
        mon_en = 0;
        check("pulses", falls, 3);
        check("width", width_ps, 24000);
        check("count", err_count, 3);
        cfg_en = 0;
        cyc(20);
        check("fail_hold", pass_out, 0);
        check("normal", link_normal, 1);
        cyc(40);
        check("fail_kept", pass_out, 0);
    endtask
    task automatic s_clean();
        en_pin = 1;
        wait_pass();
        check("count_new", err_count, 0);
        cyc(100);
        en_pin = 0;
        cyc(20);
        check("pass_hold", pass_out, 1);
        check("count", err_count, 0);
        power_down = 1;
        cyc(5);
        check("pd_clear", pass_out, 0);
        power_down = 0;
        cyc(5);
    endtask

    initial begin
        {reset_n, en_pin, sel_pin, power_down, cfg_en, cfg_osc, mon_en} = '0;
        err_bits = '0;
        strap_gp = 4'b0001;
        {fail_count, num_checks, falls, width_ps} = '0;
        repeat (4) @(posedge mclk);
        #2 reset_n = 1;
        cyc(2);
        s_clk_sel();
        s_errors();
        s_clean();
        report_and_stop();
    end
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end
endmodule

bind serial_link_bist_checker serial_link_bist_checker_properties #(.ERR_W(ERR_W)) u_props (
    .mclk(mclk), .reset_n(reset_n), .cfg_selftest_en(cfg_selftest_en),
    .cfg_osc_sel(cfg_osc_sel), .power_down(power_down), .remote_awake(remote_awake),
    .bc_frame_strobe(bc_frame_strobe), .link_lock(link_lock), .bc_out(bc_out),
    .test_clk_sel_osc(test_clk_sel_osc), .pass_out(pass_out), .lock_out(lock_out),
    .test_active(test_active), .link_normal(link_normal), .fwd_err_count(fwd_err_count));
`default_nettype wire

/* File: logic/frame_checker.sv */
/*
 * Link-clock side of the self test: payload check and pass pulse shaping.
 * Assumes frames and lock arrive on link_clk; run level comes from mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module frame_checker
    import selftest_pkg::*;
#(
    parameter int WIDTH = PAYLOAD_W
) (
    input wire logic link_clk,
    input wire logic reset_n,
    input wire logic run_req,
    input wire logic link_lock,
    input wire link_frame_t frame,
    output logic err_toggle,
    output logic pass_link
);

    // refuse widths the payload field cannot hold
    if (WIDTH < 1 || WIDTH > PAYLOAD_W) begin
        $error("frame_checker width out of range");
    end

    typedef struct packed {
        logic run_s1;
        logic run_s2;
        logic err_tg;
    } chk_state_t;

    chk_state_t cur_r;
    chk_state_t cur_nxt;
    logic neg_tg_r;
    logic bad_frame;

    // ****************************************
    // frame check
    // ****************************************
    // any set bit of the descrambled all-zero payload is an error
    assign bad_frame = frame.valid & (|frame.payload[WIDTH-1:0]);

    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.run_s1 = run_req;
        cur_nxt.run_s2 = cur_r.run_s1;
        // one toggle per errored frame, only while checking under lock
        if (cur_r.run_s2 && link_lock && bad_frame) begin
            cur_nxt.err_tg = ~cur_r.err_tg;
        end
    end

    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // falling edge copy closes the low pulse after half a period
    always_ff @(negedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            neg_tg_r <= 1'b0;
        end else begin
            neg_tg_r <= cur_r.err_tg;
        end
    end

    assign pass_link = ~(cur_r.err_tg ^ neg_tg_r);
    assign err_toggle = cur_r.err_tg;

endmodule
`default_nettype wire

/* File: logic/selftest_pkg.sv */
/*
 * Shared constants and types for the serial link self-test checker.
 * Assumes a 50 MHz system clock and a separate recovered link clock.
 */
package selftest_pkg;

    // ****************************************
    // widths and addresses
    // ****************************************
    localparam int PAYLOAD_W = 35;
    localparam int ERR_CNT_W = 8;
    localparam logic [7:0] FWD_ERR_STATUS_ADDR = 8'h25;
    localparam logic [7:0] ERR_CNT_RESET = 8'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam int MCLK_PERIOD_PS = 20000;
    localparam int DRAIN_TIME_PS = 200000;
    // least time, rounded up to whole system cycles
    localparam int DRAIN_CYC = (DRAIN_TIME_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
    localparam int DRAIN_W = 4;
    localparam int OSC_FREQ_MHZ = 33;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAKE = 3'b001,
        ST_RUN = 3'b010,
        ST_DRAIN = 3'b011,
        ST_HOLD = 3'b100
    } test_state_t;

    // one received frame at the link clock
    typedef struct packed {
        logic valid;
        logic [PAYLOAD_W-1:0] payload;
    } link_frame_t;

    // back-channel fields this block drives
    typedef struct packed {
        logic selftest_flag;
        logic wake_req;
    } back_chan_t;

endpackage

/* File: logic/serial_link_bist_checker.sv */
/*
 * Deserializer self-test controller: start and stop, back-channel request,
 * remote wake, error counting and the held pass/fail result.
 * Assumes mclk at 50 MHz, link_clk as the recovered or oscillator test clock,
 * and back-channel framing that samples bc fields on bc_frame_strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_link_bist_checker
    import selftest_pkg::*;
#(
    parameter int ERR_W = ERR_CNT_W,
    parameter int DRAIN_CYCLES = DRAIN_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic link_clk,
    // pins, asynchronous to mclk
    input wire logic selftest_enable_pin,
    input wire logic selftest_clock_select_pin,
    input wire logic power_down,
    input wire logic remote_selftest_ack,
    input wire logic remote_awake,
    // configuration bits from the same clock domain
    input wire logic cfg_selftest_en,
    input wire logic cfg_osc_sel,
    // back-channel frame boundary, mclk domain pulse
    input wire logic bc_frame_strobe,
    // link side, link_clk domain
    input wire logic link_lock,
    input wire link_frame_t frame,
    // outputs
    output back_chan_t bc_out,
    output logic test_clk_sel_osc,
    output logic pass_out,
    output logic lock_out,
    output logic test_active,
    output logic link_normal,
    output logic [ERR_W-1:0] fwd_err_count
);

    // refuse sizes the counters cannot serve
    if (ERR_W < 1 || ERR_W > 16) begin
        $error("error counter width out of range");
    end
    if (DRAIN_CYCLES < 1 || DRAIN_CYCLES >= (1 << DRAIN_W)) begin
        $error("drain count does not fit its counter");
    end

    localparam logic [DRAIN_W-1:0] DRAIN_LOAD = DRAIN_W'(DRAIN_CYCLES);
    localparam logic [ERR_W-1:0] ERR_MAX = {ERR_W{1'b1}};

    // ****************************************
    // state of the system-clock side
    // ****************************************
    typedef struct packed {
        test_state_t state;
        logic en_s1;
        logic en_s2;
        logic cs_s1;
        logic cs_s2;
        logic pd_s1;
        logic pd_s2;
        logic ack_s1;
        logic ack_s2;
        logic awake_s1;
        logic awake_s2;
        logic lock_s1;
        logic lock_s2;
        logic tg_s1;
        logic tg_s2;
        logic tg_s3;
        logic [ERR_W-1:0] err_cnt;
        logic [DRAIN_W-1:0] drain_cnt;
        logic result_err;
        logic bc_flag;
        logic wake;
        logic osc_sel;
        logic lock_o;
    } ctl_state_t;

    ctl_state_t cur_r;
    ctl_state_t cur_nxt;

    logic err_toggle;
    logic pass_link;
    logic start_req;
    logic err_event;
    logic run_level;

    // ****************************************
    // link-clock checker
    // ****************************************
    // run level crosses into the link domain inside the checker
    frame_checker #(
        .WIDTH(PAYLOAD_W)
    ) u_frame_checker (
        .link_clk(link_clk),
        .reset_n(reset_n),
        .run_req(run_level),
        .link_lock(link_lock),
        .frame(frame),
        .err_toggle(err_toggle),
        .pass_link(pass_link)
    );

    // ****************************************
    // request decode
    // ****************************************
    // pin only after its second stage; config bit is same-domain
    assign start_req = cur_r.en_s2 | cfg_selftest_en;
    // toggle from the link domain marks one errored frame
    assign err_event = cur_r.tg_s2 ^ cur_r.tg_s3;
    assign run_level = (cur_r.state == ST_RUN);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        cur_nxt = cur_r;
        // two-stage synchronisers for every pin
        cur_nxt.en_s1 = selftest_enable_pin;
        cur_nxt.en_s2 = cur_r.en_s1;
        cur_nxt.cs_s1 = selftest_clock_select_pin;
        cur_nxt.cs_s2 = cur_r.cs_s1;
        cur_nxt.pd_s1 = power_down;
        cur_nxt.pd_s2 = cur_r.pd_s1;
        cur_nxt.ack_s1 = remote_selftest_ack;
        cur_nxt.ack_s2 = cur_r.ack_s1;
        cur_nxt.awake_s1 = remote_awake;
        cur_nxt.awake_s2 = cur_r.awake_s1;
        cur_nxt.lock_s1 = link_lock;
        cur_nxt.lock_s2 = cur_r.lock_s1;
        cur_nxt.tg_s1 = err_toggle;
        cur_nxt.tg_s2 = cur_r.tg_s1;
        cur_nxt.tg_s3 = cur_r.tg_s2;

        // clock choice follows pin or config bit
        cur_nxt.osc_sel = cur_r.cs_s2 | cfg_osc_sel;
        // lock forwarded in every state, test or not
        cur_nxt.lock_o = cur_r.lock_s2;

        // back-channel flag refreshed once per frame
        if (bc_frame_strobe) begin
            cur_nxt.bc_flag = start_req && (cur_r.state != ST_HOLD)
                && (cur_r.state != ST_DRAIN);
        end

        // count errored frames, saturating
        if (cur_r.state == ST_RUN || cur_r.state == ST_DRAIN) begin
            if (err_event && cur_r.err_cnt != ERR_MAX) begin
                cur_nxt.err_cnt = cur_r.err_cnt + 1'b1;
            end
        end

        unique case (cur_r.state)
            ST_IDLE: begin
                cur_nxt.wake = 1'b0;
                if (start_req) begin
                    cur_nxt.err_cnt = ERR_CNT_RESET;
                    cur_nxt.result_err = 1'b0;
                    cur_nxt.state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // wake the remote only if it is not already up
                cur_nxt.wake = ~cur_r.awake_s2;
                if (!start_req) begin
                    cur_nxt.wake = 1'b0;
                    cur_nxt.state = ST_IDLE;
                end else if (cur_r.ack_s2 && cur_r.lock_s2) begin
                    cur_nxt.wake = 1'b0;
                    cur_nxt.state = ST_RUN;
                end
            end
            ST_RUN: begin
                // length of the test is simply how long enable stays high
                if (!start_req) begin
                    cur_nxt.drain_cnt = DRAIN_LOAD;
                    cur_nxt.state = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                // let errors already in flight reach the counter
                if (cur_r.drain_cnt <= 1) begin
                    cur_nxt.state = ST_HOLD;
                    cur_nxt.result_err = (cur_nxt.err_cnt != ERR_CNT_RESET);
                end else begin
                    cur_nxt.drain_cnt = cur_r.drain_cnt - 1'b1;
                end
            end
            ST_HOLD: begin
                // held until a fresh test begins or power down clears it
                if (start_req) begin
                    cur_nxt.err_cnt = ERR_CNT_RESET;
                    cur_nxt.result_err = 1'b0;
                    cur_nxt.state = ST_WAKE;
                end
            end
            default: begin
                cur_nxt.state = ST_IDLE;
            end
        endcase

        // power down drops any test and any held result
        if (cur_r.pd_s2) begin
            cur_nxt.state = ST_IDLE;
            cur_nxt.result_err = 1'b0;
            cur_nxt.err_cnt = ERR_CNT_RESET;
            cur_nxt.wake = 1'b0;
            cur_nxt.bc_flag = 1'b0;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // pass: low while waiting, pulsed while checking, result when held
    always_comb begin
        unique case (cur_r.state)
            ST_RUN: pass_out = pass_link;
            ST_DRAIN: pass_out = pass_link;
            ST_HOLD: pass_out = ~cur_r.result_err;
            default: pass_out = 1'b0;
        endcase
    end

    assign bc_out.selftest_flag = cur_r.bc_flag;
    assign bc_out.wake_req = cur_r.wake;
    assign test_clk_sel_osc = cur_r.osc_sel;
    assign lock_out = cur_r.lock_o;
    assign test_active = (cur_r.state == ST_WAKE) || (cur_r.state == ST_RUN);
    // normal traffic again as soon as the test is no longer active
    assign link_normal = ~test_active;
    assign fwd_err_count = cur_r.err_cnt;

endmodule
`default_nettype wire
